// ---- design/lcd_contrast_scan.sv ----
// Contrast register, backplane scan and frontplane select drive
//
// Behaviour
// R1 - Contrast mode register lives at address FAh, register-addressed only.
// R2 - Reset clears contrast register to 00h: dimmest step, controller off.
// R3 - Bits 7:4 choose contrast step n+1 of sixteen.
// R4 - Bit 0 enables contrast control; when off level has no effect.
// R5 - Eighth duty drives backplanes 0-7; quarter duty drives 0-3.
// R6 - Third duty drives backplanes 0-2; half duty drives 0-1.
// R7 - Twenty-two frontplanes, each from its own RAM byte, all duties.
// R8 - Frontplanes show the RAM bit of the currently active backplane.
// R9 - RAM bit one gives the select drive on that frontplane.
// R10 - RAM bit zero gives the no-select drive on that frontplane.
// R11 - Glass control bits 4:2 choose duty and bias.
// R12 - Frame tick is watch clock divided by selectable power of two.
// R13 - Any write of glass control restarts the scan sequence.
// R14 - Backplanes active one at a time ascending; unused held non-select.
// R15 - Reserved bits 3:1 ignore writes and read zero.
`timescale 1ns/1ps
module lcd_contrast_scan
    import lcd_scan_pkg::*;
#(
    parameter int DIV_WIDTH = 12
) (
    // Clock, reset, enable
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       clkEn,
    // Register addressing port
    input  wire logic [7:0]                 regAddr,
    input  wire logic                       regWr,
    input  wire logic [7:0]                 regWData,
    output logic      [7:0]                 regRData,
    // Watch timer tick
    input  wire logic                       watchTick,
    // Display RAM bytes, one per frontplane
    input  wire logic [NUM_FRONTPLANES*8-1:0] dispRam,
    // Glass drive
    output logic      [NUM_BACKPLANES-1:0]  backplaneSel,
    output logic      [NUM_BACKPLANES-1:0]  backplaneEn,
    output logic      [NUM_FRONTPLANES-1:0] frontplaneSel,
    output logic      [1:0]                 biasSel,
    output logic      [3:0]                 contrastLevel,
    output logic                            contrastOn
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] modeCtrl_q;
    logic [7:0] glassCtrl_q;
    logic       hitMode;
    logic       hitGlass;
    logic       restart;

    // R1 address decode
    assign hitMode  = regWr && (regAddr == MODE_CTRL_ADDR);
    assign hitGlass = regWr && (regAddr == GLASS_CTRL_ADDR);
    // R13 rewrite restarts scan
    assign restart  = hitGlass;

    // R2 reset clear, R15 reserved bits masked
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modeCtrl_q  <= MODE_CTRL_RESET;
            glassCtrl_q <= GLASS_CTRL_RESET;
        end else if (clkEn) begin
            if (hitMode) begin
                modeCtrl_q <= regWData & MODE_CTRL_WMASK;
            end
            if (hitGlass) begin
                glassCtrl_q <= regWData;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    logic [7:0] rdNext;
    assign rdNext = (regAddr == MODE_CTRL_ADDR)  ? modeCtrl_q :
                    (regAddr == GLASS_CTRL_ADDR) ? glassCtrl_q : 8'h00;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRData <= 8'h00;
        end else if (clkEn) begin
            regRData <= rdNext;
        end
    end

    // ****************************************************************
    // Contrast
    // ****************************************************************
    logic       enBit;
    logic [3:0] levelNext;
    assign enBit     = modeCtrl_q[CONTRAST_EN_BIT];
    // R3 level step, R4 disabled forces level inert
    assign levelNext = enBit ? modeCtrl_q[LEVEL_MSB:LEVEL_LSB] : LEVEL_OFF;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            contrastLevel <= LEVEL_OFF;
            contrastOn    <= 1'b0;
        end else if (clkEn) begin
            contrastLevel <= levelNext;
            contrastOn    <= enBit;
        end
    end

    // ****************************************************************
    // Duty decode and frame tick
    // ****************************************************************
    duty_sel_e  duty;
    logic [2:0] lastCom;
    logic [1:0] biasNext;
    logic [2:0] clkSel;
    logic [1:0] dispMode;
    logic       frameTick;

    assign duty     = duty_sel_e'(glassCtrl_q[DUTY_MSB:DUTY_LSB]);
    assign dispMode = glassCtrl_q[DISP_MSB:DISP_LSB];
    // Codes above 100 are unavailable; clamp so the divider stays sane
    assign clkSel   = (glassCtrl_q[CLKSEL_MSB:CLKSEL_LSB] > CLKSEL_MAX) ? CLKSEL_MAX
                      : glassCtrl_q[CLKSEL_MSB:CLKSEL_LSB];

    // R11 duty and bias, R5 R6 backplane count
    always_comb begin
        unique case (duty)
            DUTY8_BIAS4: begin lastCom = 3'h7; biasNext = 2'h2; end
            DUTY4_BIAS3: begin lastCom = 3'h3; biasNext = 2'h1; end
            DUTY3_BIAS3: begin lastCom = 3'h2; biasNext = 2'h1; end
            DUTY3_BIAS2: begin lastCom = 3'h2; biasNext = 2'h0; end
            // Undefined codes fall back to half duty
            default:     begin lastCom = 3'h1; biasNext = 2'h0; end
        endcase
    end

    frame_divider #(
        .WIDTH     (DIV_WIDTH)
    ) u_div (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clkEn     (clkEn),
        .restart   (restart),
        .watchTick (watchTick),
        .clkSel    (clkSel),
        .frameTick (frameTick)
    );

    // ****************************************************************
    // Backplane scan
    // ****************************************************************
    logic [2:0] com_q;
    logic [2:0] com_d;
    // R14 ascending, wrap after last enabled line
    assign com_d = (com_q >= lastCom) ? 3'h0 : com_q + 3'h1;

    // R13 restart from line 0
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            com_q <= 3'h0;
        end else if (clkEn) begin
            if (restart) begin
                com_q <= 3'h0;
            end else if (frameTick) begin
                com_q <= com_d;
            end
        end
    end

    // ****************************************************************
    // Per-line and per-segment drive
    // ****************************************************************
    logic                       dispOn;
    logic [NUM_BACKPLANES-1:0]  bpSelNext;
    logic [NUM_BACKPLANES-1:0]  bpEnNext;
    logic [NUM_FRONTPLANES-1:0] fpNext;
    assign dispOn = (dispMode != DISP_OFF);

    genvar gi;
    // R5 R6 enabled lines, R14 one active line
    for (gi = 0; gi < NUM_BACKPLANES; gi++) begin : g_bp
        assign bpEnNext[gi]  = dispOn && (gi <= int'(lastCom));
        assign bpSelNext[gi] = bpEnNext[gi] && (com_q == 3'(gi));
    end
    // R7 one byte per frontplane, R8 bit of active line, R9 R10 select
    for (gi = 0; gi < NUM_FRONTPLANES; gi++) begin : g_fp
        assign fpNext[gi] = (dispMode == DISP_ALL_ON) ||
                            ((dispMode == DISP_NORMAL) && dispRam[gi*8 + int'(com_q)]);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            backplaneSel  <= '0;
            backplaneEn   <= '0;
            frontplaneSel <= '0;
            biasSel       <= 2'h0;
        end else if (clkEn) begin
            backplaneSel  <= bpSelNext;
            backplaneEn   <= bpEnNext;
            frontplaneSel <= fpNext;
            biasSel       <= biasNext;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_modeWrite;
        clkEn && hitMode;
    endsequence

    AST_MODE_RESERVED: assert property (s_modeWrite |=> modeCtrl_q[3:1] == 3'h0) // R15
        else $error("reserved bits not zero");
    AST_MODE_STORE: assert property (s_modeWrite |=> modeCtrl_q[7:4] == $past(regWData[7:4])) // R1
        else $error("mode write lost");
    AST_LEVEL: assert property (clkEn && enBit |=> contrastLevel == $past(modeCtrl_q[7:4])) // R3
        else $error("level mismatch");
    AST_DISABLED: assert property (clkEn && !enBit |=> contrastLevel == LEVEL_OFF && !contrastOn) // R4
        else $error("disabled contrast active");
    AST_RESTART: assert property (clkEn && restart |=> com_q == 3'h0) // R13
        else $error("scan not restarted");
    AST_COM_RANGE: assert property (com_q <= lastCom || $past(restart) || $changed(lastCom)) // R14
        else $error("line beyond duty");
    AST_ONEHOT: assert property ($onehot0(backplaneSel)) // R14
        else $error("several lines active");
    AST_DUTY8: assert property (clkEn && dispOn && duty == DUTY8_BIAS4 |=> backplaneEn == 8'hFF) // R5
        else $error("eighth duty lines");
    AST_DUTY3: assert property (clkEn && dispOn && duty == DUTY3_BIAS3 |=> backplaneEn == 8'h07) // R6
        else $error("third duty lines");
    AST_SEG: assert property (clkEn && dispMode == DISP_NORMAL |=>
                              frontplaneSel[0] == $past(dispRam[int'(com_q)])) // R9
        else $error("segment drive wrong");
    AST_RESET_VAL: assert property ($fell(rst) |-> modeCtrl_q == MODE_CTRL_RESET) // R2
        else $error("reset value wrong");
endmodule

// ---- design/lcd_scan_pkg.sv ----
// Constants and types shared by the contrast and scan drive block
package lcd_scan_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] MODE_CTRL_ADDR  = 8'hFA;
    localparam logic [7:0] GLASS_CTRL_ADDR = 8'hF9;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] GLASS_CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_CTRL_WMASK = 8'hF1;
    localparam int         LEVEL_MSB       = 7;
    localparam int         LEVEL_LSB       = 4;
    localparam int         CONTRAST_EN_BIT = 0;
    localparam int         CLKSEL_MSB      = 7;
    localparam int         CLKSEL_LSB      = 5;
    localparam int         DUTY_MSB        = 4;
    localparam int         DUTY_LSB        = 2;
    localparam int         DISP_MSB        = 1;
    localparam int         DISP_LSB        = 0;

    // ****************************************************************
    // Glass geometry and timing
    // ****************************************************************
    localparam int         NUM_BACKPLANES  = 8;
    localparam int         NUM_FRONTPLANES = 22;
    localparam int         DIV_BASE_LOG2   = 8;
    localparam logic [2:0] CLKSEL_MAX      = 3'h4;
    localparam logic [3:0] LEVEL_OFF       = 4'h0;

    // Duty and bias selections
    typedef enum logic [2:0] {
        DUTY8_BIAS4 = 3'b000,
        DUTY4_BIAS3 = 3'b001,
        DUTY3_BIAS3 = 3'b010,
        DUTY3_BIAS2 = 3'b011
    } duty_sel_e;

    // Display control
    localparam logic [1:0] DISP_OFF     = 2'h0;
    localparam logic [1:0] DISP_ALL_OFF = 2'h1;
    localparam logic [1:0] DISP_ALL_ON  = 2'h2;
    localparam logic [1:0] DISP_NORMAL  = 2'h3;
endpackage

// ---- design/frame_divider.sv ----
// Power-of-two divider of the watch clock tick into a frame scan tick
`timescale 1ns/1ps
module frame_divider
    import lcd_scan_pkg::*;
#(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clkEn,
    // Control
    input  wire logic       restart,
    input  wire logic       watchTick,
    input  wire logic [2:0] clkSel,
    // Result
    output logic            frameTick
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic [WIDTH-1:0] limit;

    // Tick period is 2^(8-sel) watch ticks
    assign limit   = WIDTH'((1 << (DIV_BASE_LOG2 - int'(clkSel))) - 1);
    assign count_d = (count_q == limit) ? '0 : count_q + WIDTH'(1);

    // R12 watch clock divide
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_q   <= '0;
            frameTick <= 1'b0;
        end else if (clkEn) begin
            frameTick <= !restart && watchTick && (count_q == limit);
            if (restart) begin
                count_q <= '0;
            end else if (watchTick) begin
                count_q <= count_d;
            end
        end
    end
endmodule

// ---- sim/lcd_glass_model.sv ----
// Passive glass model that checks frontplane drive against display RAM
`timescale 1ns/1ps
module lcd_glass_model
    import lcd_scan_pkg::*;
(
    // Clock and bench control
    input wire logic                         clk_sys,
    input wire logic                         normal,
    input wire logic                         clear,
    // Glass lines and RAM image
    input wire logic [NUM_FRONTPLANES*8-1:0] dispRam,
    input wire logic [NUM_BACKPLANES-1:0]    backplaneSel,
    input wire logic [NUM_FRONTPLANES-1:0]   frontplaneSel
);
    int                        lineQ[$];
    int                        timeQ[$];
    int                        errs = 0;
    int                        cyc = 0;
    int                        line;
    logic [NUM_BACKPLANES-1:0] lastSel = '0;

    // Glass draws no current on its own, so it drives nothing back
    always @(posedge clk_sys) begin
        cyc++;
        if (clear) begin
            lineQ.delete();
            timeQ.delete();
            lastSel = '0;
        end else if (backplaneSel != 0) begin
            for (int j = 0; j < NUM_BACKPLANES; j++) begin
                if (backplaneSel[j]) line = j;
            end
            if ($countones(backplaneSel) != 1) errs++;
            if (backplaneSel != lastSel) begin
                lineQ.push_back(line);
                timeQ.push_back(cyc);
            end
            lastSel = backplaneSel;
            for (int k = 0; k < NUM_FRONTPLANES; k++) begin
                if (normal && frontplaneSel[k] !== dispRam[8*k+line]) errs++;
            end
        end
    end
endmodule

// ---- sim/tb_lcd_contrast_scan.sv ----
// Self-checking bench for the contrast and scan drive block
`timescale 1ns/1ps
module tb_lcd_contrast_scan
    import lcd_scan_pkg::*;
;
    logic                         clk_sys = 0, rst = 1, regWr = 0, normal = 0, clear = 0;
    logic                         clkEn = 1, watchTick = 1, slowTick = 0;
    logic [7:0]                   regAddr = 8'h00, regWData = 8'h00, lvl;
    logic [NUM_FRONTPLANES*8-1:0] dispRam = '0;
    logic [7:0]                   regRData;
    logic [NUM_BACKPLANES-1:0]    backplaneSel, backplaneEn;
    logic [NUM_FRONTPLANES-1:0]   frontplaneSel;
    logic [1:0]                   biasSel;
    logic [3:0]                   contrastLevel;
    logic                         contrastOn;
    int                           bad_count = 0, checks_done = 0, seed = 68120, n, w;
    int                           masks[5] = '{255, 15, 7, 7, 3};
    int                           bias[5] = '{2, 1, 1, 0, 0};
    int                           lines[5] = '{8, 4, 3, 3, 2};

    always #20 clk_sys = ~clk_sys;

    // Halved tick rate shows that the divider counts ticks, not clocks
    always @(negedge clk_sys)
        watchTick <= slowTick ? !watchTick : 1'b1;

    // Watch tick every cycle, or every other cycle in the frame rate test
    lcd_contrast_scan uut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWr(regWr), .regWData(regWData), .regRData(regRData), .watchTick(watchTick),
        .dispRam(dispRam), .backplaneSel(backplaneSel), .backplaneEn(backplaneEn),
        .frontplaneSel(frontplaneSel), .biasSel(biasSel), .contrastLevel(contrastLevel),
        .contrastOn(contrastOn));

    lcd_glass_model glass (.clk_sys(clk_sys), .normal(normal), .clear(clear),
        .dispRam(dispRam), .backplaneSel(backplaneSel), .frontplaneSel(frontplaneSel));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (bad_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Write strobe spans exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regWr = 1;
        regWData = d;
        @(negedge clk_sys);
        regWr = 0;
    endtask

    // Read data is registered one edge after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        regAddr = a;
        @(negedge clk_sys);
        chk(regRData, exp);
    endtask

    // Model checking paused around the rewrite, which may glitch
    task automatic glass_wr(input logic [7:0] d);
        normal = 0;
        wr(GLASS_CTRL_ADDR, d);
        repeat (3) @(negedge clk_sys);
        clear = 1;
        @(negedge clk_sys);
        clear = 0;
        normal = (d[1:0] == DISP_NORMAL);
    endtask

    task automatic wait_lines(input int k);
        for (int i = 0; i < 3000 && glass.lineQ.size() < k; i++)
            @(posedge clk_sys);
        @(negedge clk_sys);
        chk(glass.lineQ.size() >= k, 1);
    endtask

    initial begin
        #(40 * 40000);
        bad_count++;
        finish_test;
    end

    initial begin
        for (n = 0; n < NUM_FRONTPLANES; n++)
            dispRam[8*n+:8] = 8'($random(seed));
        repeat (2) @(negedge clk_sys);
        rst = 0;
        rd(MODE_CTRL_ADDR, 8'h00);
        rd(GLASS_CTRL_ADDR, 8'h00);
        chk(contrastOn, 0);
        for (n = 0; n < 16; n++) begin
            lvl = {n[3:0], 3'($random(seed)), 1'b1};
            wr(MODE_CTRL_ADDR, lvl);
            rd(MODE_CTRL_ADDR, lvl & 8'hF1);
            chk(contrastLevel, n);
            chk(contrastOn, 1);
        end
        wr(MODE_CTRL_ADDR, 8'hF0);
        rd(MODE_CTRL_ADDR, 8'hF0);
        chk(contrastLevel, 0);
        chk(contrastOn, 0);
        wr(8'hFB, 8'hFF);
        rd(MODE_CTRL_ADDR, 8'hF0);
        rd(8'hFB, 8'h00);
        for (n = 0; n < 5; n++) begin
            glass_wr({3'h4, n[2:0], DISP_NORMAL});
            wait_lines(2 * lines[n]);
            for (w = 0; w < 2 * lines[n]; w++)
                chk(glass.lineQ[w], w % lines[n]);
            chk(backplaneEn, masks[n]);
            chk(biasSel, bias[n]);
        end
        slowTick = 1;
        for (n = 0; n < 6; n++) begin
            glass_wr({n[2:0], DUTY8_BIAS4, DISP_NORMAL});
            wait_lines(3);
            chk(glass.timeQ[2] - glass.timeQ[1], 2 * 2 ** (8 - (n > 4 ? 4 : n)));
        end
        slowTick = 0;
        chk(glass.errs, 0);
        for (n = 0; n < 3; n++) begin
            glass_wr({3'h4, 3'h0, n[1:0]});
            repeat (40) @(negedge clk_sys);
            if (n == 0)
                chk(backplaneSel, 0);
            else
                chk(frontplaneSel, n == 2 ? 22'h3FFFFF : 22'h0);
        end
        // Enable low freezes scan and refuses register writes
        clkEn = 0;
        w = int'(backplaneSel);
        wr(MODE_CTRL_ADDR, 8'h51);
        repeat (40) @(negedge clk_sys);
        chk(backplaneSel, w);
        clkEn = 1;
        rd(MODE_CTRL_ADDR, 8'hF0);
        rst = 1;
        @(negedge clk_sys);
        chk(backplaneSel, 0);
        chk(backplaneEn, 0);
        chk(frontplaneSel, 0);
        rst = 0;
        rd(MODE_CTRL_ADDR, 8'h00);
        rd(GLASS_CTRL_ADDR, 8'h00);
        finish_test;
    end
endmodule
